// ===== src/tncfg_top.sv
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ns
module tncfg_top (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       nrst_in,
  // Register port
  input  wire logic [3:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  // Network events
  input  wire logic       refusal_in,
  input  wire logic       pkt_valid_in,
  input  wire logic [7:0] pkt_dest_in,
  // Line, receive decisions and timing
  input  wire logic       pulse_level_in,
  output logic            first_line_pulse_output_out,
  output logic            first_line_pulse_oe_out,
  output logic            pkt_accept_out,
  output logic            pkt_ack_out,
  output logic            rate_tick_out,
  output logic            arb_tick_out
);
  logic [7:0] cfg_q;
  logic [7:0] ctl_q;
  logic [7:0] node_q;
  logic       flag_q;
  logic [7:0] refuse_q;
  logic [6:0] div_q;
  logic       arb_q;
  logic [7:0] rdata_q;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire wr_cfg  = wr_in && addr_in == tncfg_pkg::ADDR_CONFIG;
  wire wr_ctl  = wr_in && addr_in == tncfg_pkg::ADDR_CONTROL;
  wire wr_node = wr_in && addr_in == tncfg_pkg::ADDR_NODE_ID;
  wire wr_stat = wr_in && addr_in == tncfg_pkg::ADDR_STATUS;
  wire       drv_type  = cfg_q[tncfg_pkg::BIT_DRV_TYPE];
  wire       short_thr = cfg_q[tncfg_pkg::BIT_SHORT_THR];
  wire       promisc   = cfg_q[tncfg_pkg::BIT_PROMISC];
  wire [2:0] pre_sel   = cfg_q[tncfg_pkg::BIT_PRE_HI:tncfg_pkg::BIT_PRE_LO];
  wire       arb_halve = cfg_q[tncfg_pkg::BIT_ARB_HALVE];
  wire       backplane = ctl_q[tncfg_pkg::BIT_BACKPLANE];

  function automatic logic [6:0] div_last(input logic [2:0] sel);
    case (sel)
      3'h0:    div_last = 7'h07;
      3'h1:    div_last = 7'h0F;
      3'h2:    div_last = 7'h1F;
      3'h3:    div_last = 7'h3F;
      default: div_last = tncfg_pkg::DIV_MAX;
    endcase
  endfunction

  wire [6:0] div_end    = div_last(pre_sel);
  wire       rate_tick  = div_q >= div_end;
  wire [7:0] refuse_thr = short_thr ? tncfg_pkg::REFUSE_SHORT
                                    : tncfg_pkg::REFUSE_LONG;
  wire       refuse_hit = refusal_in && (refuse_q + 8'h01 >= refuse_thr);
  wire       dest_match = pkt_dest_in == node_q;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_q  <= tncfg_pkg::CONFIG_RESET;
      ctl_q  <= 8'h00;
      node_q <= 8'h00;
    end else begin
      if (wr_cfg) begin
        cfg_q <= wdata_in & tncfg_pkg::CONFIG_WMASK;
      end
      if (wr_ctl) begin
        ctl_q <= {7'h00, wdata_in[tncfg_pkg::BIT_BACKPLANE]};
      end
      if (wr_node) begin
        node_q <= wdata_in;
      end
    end
  end

  // ----------------------------------------
  // Refusal counter and flag
  // ----------------------------------------
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      refuse_q <= 8'h00;
      flag_q   <= 1'b0;
    end else begin
      if (refuse_hit) begin
        refuse_q <= 8'h00;
      end else if (refusal_in) begin
        refuse_q <= refuse_q + 8'h01;
      end
      if (refuse_hit) begin
        flag_q <= 1'b1;
      end else if (wr_stat && wdata_in[tncfg_pkg::BIT_FLAG]) begin
        flag_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Rate and arbitration dividers
  // ----------------------------------------
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_q <= 7'h00;
      arb_q <= 1'b0;
    end else begin
      div_q <= rate_tick ? 7'h00 : div_q + 7'h01;
      arb_q <= arb_halve ? ~arb_q : 1'b1;
    end
  end

  assign rate_tick_out = rate_tick;
  assign arb_tick_out  = arb_halve ? arb_q : 1'b1;

  // ----------------------------------------
  // Receive decisions
  // ----------------------------------------
  assign pkt_accept_out = pkt_valid_in && (promisc || dest_match);
  assign pkt_ack_out    = pkt_valid_in && dest_match;

  // ----------------------------------------
  // First pulse driver
  // ----------------------------------------
  wire push_pull = !backplane || drv_type;
  assign first_line_pulse_output_out = push_pull ? pulse_level_in : 1'b0;
  assign first_line_pulse_oe_out     = push_pull || !pulse_level_in;

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  wire [7:0] rd_mux =
    addr_in == tncfg_pkg::ADDR_CONFIG  ? cfg_q :
    addr_in == tncfg_pkg::ADDR_CONTROL ? ctl_q :
    addr_in == tncfg_pkg::ADDR_NODE_ID ? node_q :
    addr_in == tncfg_pkg::ADDR_STATUS  ? {7'h00, flag_q} : 8'h00;

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd_in ? rd_mux : 8'h00;
    end
  end
  assign rdata_out = rdata_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_ACK_MATCH: assert property (@(posedge clock_in) disable iff (!nrst_in)
    pkt_ack_out |-> pkt_dest_in == node_q)
    else $error("ack for foreign destination");
  AST_PROMISC: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (pkt_valid_in && promisc) |-> pkt_accept_out)
    else $error("receive-all packet dropped");
  AST_SHORT_THR: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (short_thr && refusal_in && refuse_q == 8'h03 && !wr_cfg) |=> flag_q)
    else $error("flag not set after four refusals");
  AST_LONG_THR: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (!short_thr && refusal_in && refuse_q == 8'h7E && !flag_q) |=> !flag_q)
    else $error("flag set before 128 refusals");
  // Period checks only over windows with no config write
  AST_DIV8: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (rate_tick && pre_sel == 3'h0 && !wr_cfg) ##1 (!wr_cfg [*7]) |=>
      rate_tick &&
      !$past(rate_tick, 1) &&
      !$past(rate_tick, 2) &&
      !$past(rate_tick, 3) &&
      !$past(rate_tick, 4) &&
      !$past(rate_tick, 5) &&
      !$past(rate_tick, 6) &&
      !$past(rate_tick, 7))
    else $error("divide by 8 wrong");
  AST_DIV16: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (rate_tick && pre_sel == 3'h1 && !wr_cfg) ##1 (!wr_cfg [*8]) ##1 (!wr_cfg [*7])
      |=> rate_tick)
    else $error("divide by 16 wrong");
  AST_TICK_GAP: assert property (@(posedge clock_in) disable iff (!nrst_in)
    rate_tick |=> !rate_tick)
    else $error("rate tick wider than one cycle");
  AST_DIV_WRAP: assert property (@(posedge clock_in) disable iff (!nrst_in)
    rate_tick |=> div_q == 7'h00)
    else $error("rate divider did not wrap");
  AST_DIV_COUNT: assert property (@(posedge clock_in) disable iff (!nrst_in)
    !rate_tick |=> div_q == $past(div_q) + 7'h01)
    else $error("rate divider did not count");
  AST_ARB: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (arb_halve && !wr_cfg && $past(arb_halve)) |=> arb_tick_out != $past(arb_tick_out))
    else $error("arbitration not halved");
  AST_OD: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (backplane && !drv_type) |-> !first_line_pulse_output_out)
    else $error("open drain drives high");
  AST_RST_CFG: assert property (@(posedge clock_in)
    $rose(nrst_in) |-> cfg_q == tncfg_pkg::CONFIG_RESET)
    else $error("config reset value wrong");
  AST_RD: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (rd_in && addr_in == tncfg_pkg::ADDR_CONTROL) |=> rdata_out == {7'h00, $past(backplane)})
    else $error("control readback wrong");

  // ----------------------------------------
  // Divider end points and arbitration enable
  // ----------------------------------------
  AST_END_8: assert property (@(posedge clock_in) disable iff (!nrst_in)
    pre_sel == 3'h0 |-> div_end == 7'h07)
    else $error("end point for divide by 8 wrong");
  AST_END_16: assert property (@(posedge clock_in) disable iff (!nrst_in)
    pre_sel == 3'h1 |-> div_end == 7'h0F)
    else $error("end point for divide by 16 wrong");
  AST_END_32: assert property (@(posedge clock_in) disable iff (!nrst_in)
    pre_sel == 3'h2 |-> div_end == 7'h1F)
    else $error("end point for divide by 32 wrong");
  AST_END_64: assert property (@(posedge clock_in) disable iff (!nrst_in)
    pre_sel == 3'h3 |-> div_end == 7'h3F)
    else $error("end point for divide by 64 wrong");
  AST_END_128: assert property (@(posedge clock_in) disable iff (!nrst_in)
    pre_sel >= 3'h4 |-> div_end == 7'h7F)
    else $error("end point for divide by 128 wrong");
  AST_ARB_FULL: assert property (@(posedge clock_in) disable iff (!nrst_in)
    !arb_halve |-> arb_tick_out)
    else $error("arbitration enable missing at full speed");
  AST_ARB_ALT: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (arb_halve && $past(arb_halve) && arb_tick_out && !wr_cfg) |=> !arb_tick_out)
    else $error("arbitration enable not alternating");

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  AST_RST_CTL: assert property (@(posedge clock_in)
    $rose(nrst_in) |-> ctl_q == 8'h00)
    else $error("control reset value wrong");
  AST_RST_NODE: assert property (@(posedge clock_in)
    $rose(nrst_in) |-> node_q == 8'h00)
    else $error("node id reset value wrong");
  AST_RST_FLAG: assert property (@(posedge clock_in)
    $rose(nrst_in) |-> !flag_q && refuse_q == 8'h00)
    else $error("refusal state reset value wrong");
  AST_RST_RDATA: assert property (@(posedge clock_in)
    $rose(nrst_in) |-> rdata_out == 8'h00)
    else $error("read data reset value wrong");

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  AST_RESERVED: assert property (@(posedge clock_in) disable iff (!nrst_in)
    cfg_q[5] == 1'b0)
    else $error("reserved config bit set");
  AST_CFG_WRITE: assert property (@(posedge clock_in) disable iff (!nrst_in)
    wr_cfg |=> cfg_q == ($past(wdata_in) & tncfg_pkg::CONFIG_WMASK))
    else $error("config write lost");
  AST_CFG_HOLD: assert property (@(posedge clock_in) disable iff (!nrst_in)
    !wr_cfg |=> $stable(cfg_q))
    else $error("config changed without write");
  AST_CTL_HOLD: assert property (@(posedge clock_in) disable iff (!nrst_in)
    !wr_ctl |=> $stable(ctl_q))
    else $error("control changed without write");
  AST_NODE_WRITE: assert property (@(posedge clock_in) disable iff (!nrst_in)
    wr_node |=> node_q == $past(wdata_in))
    else $error("node id write lost");

  // ----------------------------------------
  // Refusal counter and flag
  // ----------------------------------------
  AST_FLAG_HOLD: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (flag_q && !(wr_stat && wdata_in[tncfg_pkg::BIT_FLAG])) |=> flag_q)
    else $error("refusal flag lost");
  AST_FLAG_CLEAR: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (wr_stat && wdata_in[tncfg_pkg::BIT_FLAG] && !refuse_hit) |=> !flag_q)
    else $error("refusal flag not cleared");
  AST_SET_WINS: assert property (@(posedge clock_in) disable iff (!nrst_in)
    refuse_hit |=> flag_q)
    else $error("refusal flag set lost");
  AST_CNT_IDLE: assert property (@(posedge clock_in) disable iff (!nrst_in)
    !refusal_in |=> $stable(refuse_q))
    else $error("refusal count moved without refusal");
  AST_CNT_LIMIT: assert property (@(posedge clock_in) disable iff (!nrst_in)
    refuse_q < 8'h80)
    else $error("refusal count beyond threshold");

  // ----------------------------------------
  // Read port, receive decisions and pulse driver
  // ----------------------------------------
  AST_RD_IDLE: assert property (@(posedge clock_in) disable iff (!nrst_in)
    !rd_in |=> rdata_out == 8'h00)
    else $error("read data outside read cycle");
  AST_RD_CFG: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (rd_in && addr_in == tncfg_pkg::ADDR_CONFIG) |=> rdata_out == $past(cfg_q))
    else $error("config readback wrong");
  AST_RD_NODE: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (rd_in && addr_in == tncfg_pkg::ADDR_NODE_ID) |=> rdata_out == $past(node_q))
    else $error("node id readback wrong");
  AST_RD_STAT: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (rd_in && addr_in == tncfg_pkg::ADDR_STATUS) |=> rdata_out == {7'h00, $past(flag_q)})
    else $error("status readback wrong");
  AST_RX_IDLE: assert property (@(posedge clock_in) disable iff (!nrst_in)
    !pkt_valid_in |-> !pkt_accept_out && !pkt_ack_out)
    else $error("receive decision without packet");
  AST_FILTER: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (pkt_valid_in && !promisc && pkt_dest_in != node_q) |-> !pkt_accept_out)
    else $error("foreign packet accepted");
  AST_ACK_OWN: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (pkt_valid_in && pkt_dest_in == node_q) |-> pkt_ack_out && pkt_accept_out)
    else $error("own packet not acknowledged");
  AST_PP: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (!backplane || drv_type) |->
      first_line_pulse_oe_out && first_line_pulse_output_out == pulse_level_in)
    else $error("push pull drive wrong");
  AST_OD_RELEASE: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (backplane && !drv_type) |-> first_line_pulse_oe_out == !pulse_level_in)
    else $error("open drain enable wrong");
endmodule

// ===== include/tncfg_pkg.sv
// How it works
// - In backplane mode, pulse output is push/pull when type bit high, else open drain.
// - Refusal flag sets after four refusals if bit set, else after 128.
// - Receive-all bit accepts every valid packet regardless of destination; resets low.
// - Acknowledgements go only to packets addressed to own node identifier.
// - Prescaler codes 000..100 divide base clock by 8, 16, 32, 64, 128.
// - Prescaler resets to 000, fastest rate; slowest is divide by 128.
// - Slow-arbitration bit halves the memory arbitration clock.
// - A separate control bit selects backplane signalling where the type bit applies.
package tncfg_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [3:0] ADDR_CONFIG  = 4'h0;
  localparam logic [3:0] ADDR_CONTROL = 4'h1;
  localparam logic [3:0] ADDR_NODE_ID = 4'h2;
  localparam logic [3:0] ADDR_STATUS  = 4'h3;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] CONFIG_WMASK = 8'hDF;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_DRV_TYPE  = 7;
  localparam int BIT_SHORT_THR = 6;
  localparam int BIT_PROMISC   = 4;
  localparam int BIT_PRE_HI    = 3;
  localparam int BIT_PRE_LO    = 1;
  localparam int BIT_ARB_HALVE = 0;
  localparam int BIT_BACKPLANE = 0;
  localparam int BIT_FLAG      = 0;
  // ----------------------------------------
  // Counts
  // ----------------------------------------
  localparam logic [7:0] REFUSE_SHORT = 8'h04;
  localparam logic [7:0] REFUSE_LONG  = 8'h80;
  localparam logic [6:0] DIV_MAX      = 7'h7F;
endpackage

// ===== dv/tncfg_host.sv
`timescale 1ns/1ns
module tncfg_host (
  // Bus
  input  wire logic       clock_in,
  input  wire logic [7:0] rdata_in,
  output logic      [3:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out
);
  initial begin
    addr_out = 4'h0;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // Base clock only, so any prescaler code and either arbitration speed is legal
  task automatic write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr_out <= a;
    wdata_out <= (a == 4'h0) ? (d & 8'hDF) : d;
    wr_out <= 1'b1;
    @(posedge clock_in);
    wr_out <= 1'b0;
  endtask
  task automatic read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clock_in);
    rd_out <= 1'b0;
    #1 d = rdata_in;
  endtask
endmodule

// ===== dv/test_token_net_config_register.sv
`timescale 1ns/1ns
module test_token_net_config_register;
  logic       clock_in, nrst_in, refusal_in, pkt_valid_in, pulse_level_in, wr_in, rd_in;
  logic [7:0] pkt_dest_in, rdata_out, wdata_in, r;
  logic [3:0] addr_in;
  logic       p_out, p_oe, acc, ack, rate_tick, arb_tick;
  int         mismatches, n_checks, k;
  tncfg_top dut_u (.clock_in(clock_in), .nrst_in(nrst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .refusal_in(refusal_in), .pkt_valid_in(pkt_valid_in), .pkt_dest_in(pkt_dest_in),
    .pulse_level_in(pulse_level_in), .first_line_pulse_output_out(p_out),
    .first_line_pulse_oe_out(p_oe), .pkt_accept_out(acc), .pkt_ack_out(ack),
    .rate_tick_out(rate_tick), .arb_tick_out(arb_tick));
  tncfg_host host_u (.clock_in(clock_in), .rdata_in(rdata_out), .addr_out(addr_in),
    .wdata_out(wdata_in), .wr_out(wr_in), .rd_out(rd_in));
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Cycles up to the next rate tick, bounded
  task automatic wt(output int c);
    c = 0;
    do begin
      @(negedge clock_in);
      c++;
    end while (rate_tick !== 1'b1 && c < 300);
    if (c >= 300) begin
      mismatches++;
      test_done();
    end
  endtask
  task automatic refuse(input int n);
    repeat (n) begin
      @(posedge clock_in) refusal_in <= 1'b1;
      @(posedge clock_in) refusal_in <= 1'b0;
    end
  endtask
  task automatic pk(input logic [7:0] d, input logic [7:0] e);
    @(posedge clock_in) pkt_dest_in <= d;
    @(negedge clock_in) chk({6'h00, acc, ack}, e);
  endtask
  task automatic pl(input logic l, input logic [7:0] e);
    @(posedge clock_in) pulse_level_in <= l;
    @(negedge clock_in) chk({6'h00, p_oe, p_out}, e);
  endtask
  initial begin
    {nrst_in, refusal_in, pkt_valid_in, pulse_level_in} = 4'h1;
    pkt_dest_in = 8'h00;
    repeat (3) @(posedge clock_in);
    nrst_in <= 1'b1;
    pl(1'b1, 8'h03);
    host_u.read(4'h0, r);
    chk(r, 8'h00);
    host_u.read(4'h5, r);
    chk(r, 8'h00);
    for (int c = 0; c < 5; c++) begin
      host_u.write(4'h0, 8'(c << 1));
      wt(k);
      wt(k);
      wt(k);
      chk(8'(k), 8'(8 << c));
    end
    host_u.write(4'h0, 8'h01);
    k = 0;
    repeat (8) @(negedge clock_in) k += int'(arb_tick);
    chk(8'(k), 8'h04);
    host_u.write(4'h0, 8'h40);
    refuse(3);
    host_u.read(4'h3, r);
    chk(r & 8'h01, 8'h00);
    refuse(1);
    host_u.read(4'h3, r);
    chk(r & 8'h01, 8'h01);
    host_u.write(4'h3, 8'h01);
    host_u.write(4'h0, 8'h00);
    refuse(127);
    host_u.read(4'h3, r);
    chk(r & 8'h01, 8'h00);
    refuse(1);
    host_u.read(4'h3, r);
    chk(r & 8'h01, 8'h01);
    host_u.write(4'h2, 8'h2A);
    pkt_valid_in <= 1'b1;
    pk(8'h2A, 8'h03);
    pk(8'h11, 8'h00);
    host_u.write(4'h0, 8'h10);
    pk(8'h11, 8'h02);
    pk(8'h2A, 8'h03);
    host_u.write(4'h1, 8'h01);
    host_u.write(4'h0, 8'h00);
    pl(1'b1, 8'h00);
    pl(1'b0, 8'h02);
    host_u.write(4'h0, 8'h80);
    pl(1'b1, 8'h03);
    test_done();
  end
endmodule
